// File: hdl/pdr_bank.sv
/*
 Register bank for one integrated copper port: cable diagnostic control and
 result, link status, symbol-error frame counter, event flags with enables,
 and crossover control. Assumes a synchronous master on the strobe port and
 a cable test engine that answers a start pulse with a done pulse and code.
*/
// The plain strobed port was chosen for this implementation.
module pdr_bank (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [11:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  output logic diag_start,
  output logic diag_pair,
  input wire logic diag_done,
  input wire logic [1:0] diag_code,
  input wire logic link_up,
  input wire logic receive_symbol_error_frame,
  input wire logic [7:0] event_pulse,
  output logic auto_crossover_en,
  output logic straight_wiring,
  output logic irq
);
  pdr_pkg::pdr_diag_state_t state_q;
  logic [1:0] diag_res_q;
  logic pair_q;
  logic [1:0] diag_rsv_a_q;
  logic [1:0] diag_rsv_b_q;
  logic [15:0] symerr_q;
  logic [7:0] evt_q;
  logic [7:0] evt_en_q;
  logic xo_dis_q;
  logic xo_str_q;
  logic [7:0] xo_hi_q;
  logic [5:0] xo_lo_q;
  logic wr_diag, rd_sym, rd_evt;
  logic [15:0] rdata_d;

  assign wr_diag = wr && (addr == pdr_pkg::OFF_DIAG);
  assign rd_sym = rd && (addr == pdr_pkg::OFF_SYMERR);
  assign rd_evt = rd && (addr == pdr_pkg::OFF_EVENT);

  // Diagnostic sequencer; a write of zero mid-run aborts the run
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_q <= pdr_pkg::PDR_IDLE;
      diag_start <= 1'b0;
      diag_res_q <= pdr_pkg::DIAG_RES_RESET;
    end else begin
      diag_start <= 1'b0;
      case (state_q)
        pdr_pkg::PDR_IDLE: begin
          if (wr_diag && wdata[pdr_pkg::DIAG_EN_BIT]) begin
            state_q <= pdr_pkg::PDR_RUN;
            diag_start <= 1'b1;
          end
        end
        pdr_pkg::PDR_RUN: begin
          if (wr_diag && !wdata[pdr_pkg::DIAG_EN_BIT]) begin
            state_q <= pdr_pkg::PDR_IDLE;
          end else if (diag_done) begin
            state_q <= pdr_pkg::PDR_IDLE;
            diag_res_q <= diag_code;
          end
        end
        default: state_q <= pdr_pkg::PDR_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      pair_q <= 1'b0;
      diag_rsv_a_q <= 2'h0;
      diag_rsv_b_q <= 2'h0;
    end else if (wr_diag) begin
      pair_q <= wdata[pdr_pkg::DIAG_PAIR_BIT];
      diag_rsv_a_q <= wdata[14:13];
      diag_rsv_b_q <= wdata[11:10];
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      diag_pair <= 1'b0;
    end else begin
      diag_pair <= wr_diag ? wdata[pdr_pkg::DIAG_PAIR_BIT] : pair_q;
    end
  end

  // Counter saturates rather than wrapping; an error in the read cycle starts a fresh count
  always_ff @(posedge clk) begin
    if (!resetn) begin
      symerr_q <= pdr_pkg::SYMERR_RESET;
    end else if (rd_sym) begin
      symerr_q <= {15'h0000, receive_symbol_error_frame};
    end else if (receive_symbol_error_frame && symerr_q != 16'hffff) begin
      symerr_q <= symerr_q + 16'h0001;
    end
  end

  // Set wins over the read clear
  always_ff @(posedge clk) begin
    if (!resetn) begin
      evt_q <= pdr_pkg::EVT_RESET;
    end else if (rd_evt) begin
      evt_q <= event_pulse;
    end else begin
      evt_q <= evt_q | event_pulse;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      evt_en_q <= 8'h00;
    end else if (wr && addr == pdr_pkg::OFF_EVENT) begin
      evt_en_q <= wdata[15:8];
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      xo_dis_q <= 1'b0;
      xo_str_q <= 1'b0;
      xo_hi_q <= pdr_pkg::XOVER_HIGH_RESET;
      xo_lo_q <= 6'h00;
    end else if (wr && addr == pdr_pkg::OFF_XOVER) begin
      xo_dis_q <= wdata[pdr_pkg::XO_DISABLE_BIT];
      xo_str_q <= wdata[pdr_pkg::XO_STRAIGHT_BIT];
      xo_hi_q <= wdata[15:8];
      xo_lo_q <= wdata[5:0];
    end
  end

  // Straight output only matters while automatic crossover is off
  always_ff @(posedge clk) begin
    if (!resetn) begin
      auto_crossover_en <= 1'b1;
      straight_wiring <= 1'b0;
    end else begin
      auto_crossover_en <= !xo_dis_q;
      straight_wiring <= xo_dis_q && xo_str_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(evt_q & evt_en_q);
    end
  end

  always_comb begin
    rdata_d = 16'h0000;
    if (addr == pdr_pkg::OFF_DIAG) begin
      rdata_d = {state_q == pdr_pkg::PDR_RUN, diag_rsv_a_q, pair_q, diag_rsv_b_q,
                 diag_res_q, 8'h00};
    end else if (addr == pdr_pkg::OFF_LINK) begin
      rdata_d = {15'h0000, link_up};
    end else if (addr == pdr_pkg::OFF_SYMERR) begin
      rdata_d = symerr_q;
    end else if (addr == pdr_pkg::OFF_EVENT) begin
      rdata_d = {evt_en_q, evt_q};
    end else if (addr == pdr_pkg::OFF_XOVER) begin
      rdata_d = {xo_hi_q, xo_str_q, xo_dis_q, xo_lo_q};
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      rdata <= 16'h0000;
    end else if (rd) begin
      rdata <= rdata_d;
    end else begin
      rdata <= 16'h0000;
    end
  end

  a_start_runs: assert property (@(posedge clk) disable iff (!resetn)
    (state_q == pdr_pkg::PDR_IDLE && wr_diag && wdata[15]) |=> diag_start ##0
    (state_q == pdr_pkg::PDR_RUN))
    else $error("start write did not begin a run");

  a_done_ends: assert property (@(posedge clk) disable iff (!resetn)
    (state_q == pdr_pkg::PDR_RUN && diag_done && !wr_diag) |=>
    (state_q == pdr_pkg::PDR_IDLE) && (diag_res_q == $past(diag_code)))
    else $error("run did not end with result");

  a_zero_stops: assert property (@(posedge clk) disable iff (!resetn)
    (wr_diag && !wdata[15]) |=> (state_q == pdr_pkg::PDR_IDLE) && !diag_start)
    else $error("zero write left test running");

  a_symerr_clear: assert property (@(posedge clk) disable iff (!resetn)
    (rd_sym && !receive_symbol_error_frame) |=> symerr_q == 16'h0000)
    else $error("symbol counter not cleared by read");

  a_symerr_count: assert property (@(posedge clk) disable iff (!resetn)
    (!rd_sym && receive_symbol_error_frame && symerr_q < 16'hffff) |=>
    symerr_q == $past(symerr_q) + 16'h0001)
    else $error("symbol counter did not count");

  a_event_sticky: assert property (@(posedge clk) disable iff (!resetn)
    (event_pulse[0] && !rd_evt) ##1 !rd_evt[*2] |-> evt_q[0])
    else $error("event flag lost");

  a_event_clear: assert property (@(posedge clk) disable iff (!resetn)
    rd_evt |=> evt_q == $past(event_pulse))
    else $error("read did not clear flags");

  a_irq_level: assert property (@(posedge clk) disable iff (!resetn)
    ##1 irq == $past(|(evt_q & evt_en_q)))
    else $error("interrupt does not follow flags");

  a_cross_force: assert property (@(posedge clk) disable iff (!resetn)
    (!xo_dis_q) |=> !straight_wiring)
    else $error("straight select active while auto");

  // Run, event and crossover steps used by the checks below
  sequence s_start_write;
    state_q == pdr_pkg::PDR_IDLE && wr_diag && wdata[pdr_pkg::DIAG_EN_BIT];
  endsequence

  sequence s_busy_read;
    rd && addr == pdr_pkg::OFF_DIAG && state_q == pdr_pkg::PDR_RUN;
  endsequence

  sequence s_idle_read;
    rd && addr == pdr_pkg::OFF_DIAG && state_q == pdr_pkg::PDR_IDLE;
  endsequence

  sequence s_flag_enabled;
    |(event_pulse & evt_en_q) && !rd_evt && !(wr && addr == pdr_pkg::OFF_EVENT);
  endsequence

  sequence s_flags_cleared;
    rd_evt && event_pulse == 8'h00;
  endsequence

  sequence s_xover_write;
    wr && addr == pdr_pkg::OFF_XOVER;
  endsequence

  a_start_pulse: assert property (@(posedge clk) disable iff (!resetn)
    s_start_write |=> diag_start ##1 !diag_start)
    else $error("start pulse longer than one cycle");

  a_busy_reads_one: assert property (@(posedge clk) disable iff (!resetn)
    s_busy_read |=> rdata[pdr_pkg::DIAG_EN_BIT])
    else $error("running test read back as finished");

  a_idle_reads_result: assert property (@(posedge clk) disable iff (!resetn)
    s_idle_read |=> !rdata[pdr_pkg::DIAG_EN_BIT] &&
    rdata[pdr_pkg::DIAG_RES_LO +: 2] == $past(diag_res_q))
    else $error("finished test read back wrong");

  a_done_idle_ignored: assert property (@(posedge clk) disable iff (!resetn)
    (state_q == pdr_pkg::PDR_IDLE && diag_done) |=> diag_res_q == $past(diag_res_q))
    else $error("answer taken while idle");

  a_pair_output: assert property (@(posedge clk) disable iff (!resetn)
    wr_diag |=> diag_pair == $past(wdata[pdr_pkg::DIAG_PAIR_BIT]))
    else $error("pair output does not follow write");

  a_link_live: assert property (@(posedge clk) disable iff (!resetn)
    (rd && addr == pdr_pkg::OFF_LINK) |=> rdata == {15'h0000, $past(link_up)})
    else $error("link bit does not show link input");

  a_symerr_hold: assert property (@(posedge clk) disable iff (!resetn)
    (!rd_sym && !receive_symbol_error_frame) |=> symerr_q == $past(symerr_q))
    else $error("symbol counter moved without error");

  a_flags_set: assert property (@(posedge clk) disable iff (!resetn)
    (|event_pulse) |=> (evt_q & $past(event_pulse)) == $past(event_pulse))
    else $error("event did not set its flag");

  a_enable_write: assert property (@(posedge clk) disable iff (!resetn)
    (wr && addr == pdr_pkg::OFF_EVENT) |=>
    evt_en_q == $past(wdata[pdr_pkg::EVT_EN_LO +: 8]))
    else $error("enable write did not land");

  // Two edges: flag register first, then the registered request
  a_irq_raise: assert property (@(posedge clk) disable iff (!resetn)
    s_flag_enabled |=> ##1 irq)
    else $error("enabled event raised no interrupt");

  a_irq_drop: assert property (@(posedge clk) disable iff (!resetn)
    s_flags_cleared |=> ##1 !irq)
    else $error("interrupt stayed after clearing read");

  a_auto_follow: assert property (@(posedge clk) disable iff (!resetn)
    s_xover_write |=> ##1 auto_crossover_en == !$past(wdata[pdr_pkg::XO_DISABLE_BIT], 2))
    else $error("automatic crossover does not follow write");

  a_straight_follow: assert property (@(posedge clk) disable iff (!resetn)
    s_xover_write |=> ##1 straight_wiring ==
    ($past(wdata[pdr_pkg::XO_DISABLE_BIT], 2) && $past(wdata[pdr_pkg::XO_STRAIGHT_BIT], 2)))
    else $error("straight output does not follow write");
endmodule

// File: hdl/pdr_pkg.sv
/*
 Constants for the per-port diagnostic and event register bank.
 Assumes a single 50 MHz management clock and a plain strobe register port.
*/
package pdr_pkg;
  localparam int unsigned CLK_MHZ = 50;
  localparam logic [11:0] OFF_DIAG = 12'h124;
  localparam logic [11:0] OFF_LINK = 12'h126;
  localparam logic [11:0] OFF_SYMERR = 12'h12a;
  localparam logic [11:0] OFF_EVENT = 12'h136;
  localparam logic [11:0] OFF_XOVER = 12'h138;
  localparam int DIAG_EN_BIT = 15;
  localparam int DIAG_PAIR_BIT = 12;
  localparam int DIAG_RES_LO = 8;
  localparam int LINK_UP_BIT = 0;
  localparam int EVT_EN_LO = 8;
  localparam int XO_DISABLE_BIT = 6;
  localparam int XO_STRAIGHT_BIT = 7;
  localparam logic [1:0] DIAG_RES_RESET = 2'h0;
  localparam logic [15:0] SYMERR_RESET = 16'h0000;
  localparam logic [7:0] EVT_RESET = 8'h00;
  localparam logic [1:0] XOVER_RESERVED_RESET = 2'h0;
  localparam logic [7:0] XOVER_HIGH_RESET = 8'h24;
  localparam logic [1:0] RES_NONE = 2'h0;
  localparam logic [1:0] RES_OPEN = 2'h1;
  localparam logic [1:0] RES_SHORT = 2'h2;
  typedef enum logic [1:0] {
    PDR_IDLE = 2'b01,
    PDR_RUN = 2'b10
  } pdr_diag_state_t;
endpackage

// File: sim/pdr_cable_model.sv
/*
 Stand-in for the cable test engine on the far side of the bank.
 Assumes the bank pulses diag_start once per run; answers after a short
 or long delay with the code asked for by the bench.
*/
module pdr_cable_model (
  input wire logic clk,
  input wire logic diag_start,
  input wire logic [1:0] fault_code,
  input wire logic slow,
  output logic diag_done = 1'b0,
  output logic [1:0] diag_code = 2'h0
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  always @(posedge clk) begin
    diag_done <= 1'b0;
    // Code is only meaningful beside done, so keep it moving
    diag_code <= ~diag_code;
    if (diag_start) begin
      cnt <= slow ? 40 : 3;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
      if (cnt == 1) begin
        diag_done <= 1'b1;
        diag_code <= fault_code;
      end
    end
  end
endmodule

// File: sim/tb.sv
/*
 Self-checking bench for the port register bank.
 Assumes the strobe register port and the cable model beside it.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, resetn = 0, wr = 0, rd = 0, link = 0, sym = 0, slow = 0, st, p;
  logic [11:0] addr = 12'h0;
  logic [15:0] wdata = 16'h0, q, rdata, lf = 16'h4902;
  logic [7:0] ev = 8'h0, en, e;
  logic [1:0] code = 2'h0, dcode;
  logic dstart, pair, done, auto_en, straight, irq;
  int n_errors = 0, samples_checked = 0, cyc = 0, k;
  always #10 clk = ~clk;
  pdr_bank uut (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .diag_start(dstart), .diag_pair(pair), .diag_done(done),
    .diag_code(dcode), .link_up(link), .receive_symbol_error_frame(sym),
    .event_pulse(ev), .auto_crossover_en(auto_en), .straight_wiring(straight), .irq(irq));
  pdr_cable_model cab (.clk(clk), .diag_start(dstart), .fault_code(code), .slow(slow),
    .diag_done(done), .diag_code(dcode));
  function automatic logic [15:0] nx(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic logic [15:0] dx(input logic r, input logic s, input logic [1:0] c);
    return {r, 2'h0, s, 2'h0, c, 8'h0};
  endfunction
  task automatic report_and_stop;
    if (n_errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] x, input logic [15:0] g);
    samples_checked++;
    if (g !== x) begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", nm, x, g);
    end
  endtask
  // One access, then an idle cycle; read data caught mid-cycle
  task automatic bus(input logic w, input logic [11:0] a, input logic [15:0] d);
    addr <= a; wdata <= d; wr <= w; rd <= !w;
    @(posedge clk);
    wr <= 1'b0; rd <= 1'b0;
    @(negedge clk);
    q = rdata; st = dstart;
    @(posedge clk);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      report_and_stop;
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    bus(0, pdr_pkg::OFF_XOVER, 0); chk("xover", 16'h2400, q);
    chk("auto", 1, auto_en);
    bus(0, pdr_pkg::OFF_DIAG, 0); chk("diag", 16'h0, q);
    bus(0, pdr_pkg::OFF_EVENT, 0); chk("evt", 16'h0, q);
    bus(0, 12'h130, 0); chk("unmapped", 16'h0, q);
    for (int i = 0; i < 9; i++) begin
      p = lf[0]; lf = nx(lf);
      code <= i[1:0]; slow <= i[2];
      bus(1, pdr_pkg::OFF_DIAG, {3'h4, p, 12'h0}); chk("start", 1, st);
      chk("pair", p, pair);
      bus(0, pdr_pkg::OFF_DIAG, 0); chk("run", 1, q[15]);
      if (i == 8) begin
        // Abort mid-run; a late answer must not land
        code <= 2'h0;
        bus(1, pdr_pkg::OFF_DIAG, {3'h0, p, 12'h0}); chk("stop", 0, st);
        repeat (50) @(posedge clk);
        bus(0, pdr_pkg::OFF_DIAG, 0); chk("abort", dx(0, p, 2'h0 + i[1:0] + 2'h3), q);
      end else begin
        k = 0;
        do bus(0, pdr_pkg::OFF_DIAG, 0); while (q[15] === 1'b1 && k++ < 60);
        chk("diag", dx(0, p, i[1:0]), q);
      end
    end
    for (int i = 0; i < 4; i++) begin
      link <= lf[0]; lf = nx(lf);
      bus(0, pdr_pkg::OFF_LINK, 0); chk("link", {15'h0, link}, q);
    end
    for (int i = 0; i < 3; i++) begin
      k = lf[2:0] + 1; lf = nx(lf);
      repeat (k) begin sym <= 1'b1; @(posedge clk); end
      sym <= 1'b0;
      bus(0, pdr_pkg::OFF_SYMERR, 0); chk("symerr", 16'(k), q);
      bus(0, pdr_pkg::OFF_SYMERR, 0); chk("symclr", 16'h0, q);
    end
    for (int i = 0; i < 12; i++) begin
      en = i < 8 ? 8'hff : lf[15:8]; e = i < 8 ? 8'h1 << i : lf[7:0]; lf = nx(lf);
      bus(1, pdr_pkg::OFF_EVENT, {en, 8'h0});
      ev <= e; @(posedge clk); ev <= 8'h0;
      repeat (2) @(posedge clk);
      chk("irq", |(en & e), irq);
      bus(0, pdr_pkg::OFF_EVENT, 0); chk("evt", {en, e}, q);
      @(posedge clk); chk("irqclr", 0, irq);
      bus(0, pdr_pkg::OFF_EVENT, 0); chk("evtclr", {en, 8'h0}, q);
    end
    for (int i = 0; i < 4; i++) begin
      bus(1, pdr_pkg::OFF_XOVER, {8'h24, i[1:0], 6'h0});
      @(posedge clk);
      chk("auto", !i[0], auto_en);
      chk("straight", i[1] & i[0], straight);
      bus(0, pdr_pkg::OFF_XOVER, 0); chk("xover", {8'h24, i[1:0], 6'h0}, q);
    end
    // Second reset with crossover forced and enables set
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    chk("rstauto", 1, auto_en);
    chk("rststraight", 0, straight);
    bus(0, pdr_pkg::OFF_XOVER, 0); chk("rstxover", 16'h2400, q);
    bus(0, pdr_pkg::OFF_EVENT, 0); chk("rstevt", 16'h0, q);
    report_and_stop;
  end
endmodule
